// *** rtl/spi_seq_defines.vh ***
// Constants shared by the serial peripheral unit sequencer files.
`ifndef SPI_SEQ_DEFINES_VH
`define SPI_SEQ_DEFINES_VH

`define DATA_W 16
`define NUM_CMD 8
`define PTR_W 3
`define SSL_N 4
`define CNT_W 16
`define HALF_W 12
`define LEN_W 5

`define CMD_CPHA 0
`define CMD_CPOL 1
`define CMD_DIV_LO 2
`define CMD_DIV_HI 3
`define CMD_SEL_LO 4
`define CMD_SEL_HI 5
`define CMD_LSB_FIRST 7
`define CMD_LEN_LO 8
`define CMD_LEN_HI 11
`define CMD_CKD_EN 12
`define CMD_NEG_EN 13
`define CMD_NXT_EN 14
`define CMD_KEEP 15
`define CMD_RESET 16'h0000

`define LEN_SHORT_CODE 4'h8
`define LEN_SHORT_BITS 5'h08
`define NXT_EXTRA 16'h0002
`define PTR_FIRST 3'h0

`endif

// *** rtl/spi_two_entry_buffer.v ***
// Two-entry receive buffer with valid and ready on both sides.
`timescale 1ns/100ps
`include "spi_seq_defines.vh"

module spi_two_entry_buffer (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [`DATA_W-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [`DATA_W-1:0] out_data
);

  reg [`DATA_W-1:0] mem_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= {`DATA_W{1'b0}};
      mem_q[1] <= {`DATA_W{1'b0}};
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

// *** rtl/spi_bit_engine.v ***
// Serial clock generator and shifter for one master-mode transfer.
`timescale 1ns/100ps
`include "spi_seq_defines.vh"

module spi_bit_engine (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Control
  input wire abort,
  input wire start,
  input wire [`DATA_W-1:0] tx_word,
  input wire [`LEN_W-1:0] nbits,
  input wire cpol,
  input wire cpha,
  input wire lsb_first,
  input wire [`HALF_W-1:0] half_cyc,
  // Serial data
  input wire miso,
  output wire sclk,
  output wire mosi,
  // Result
  output wire done,
  output wire [`DATA_W-1:0] rx_word
);

  reg run_q;
  reg [`HALF_W-1:0] hc_q;
  reg [`HALF_W-1:0] half_q;
  reg [`LEN_W-1:0] bitk_q;
  reg [`LEN_W-1:0] nb_q;
  reg cpha_q;
  reg cpol_q;
  reg lsb_q;
  reg edge_odd_q;
  reg [`DATA_W-1:0] tx_q;
  reg [`DATA_W-1:0] rx_q;
  reg sclk_q;
  reg mosi_q;
  reg done_q;

  assign sclk = sclk_q;
  assign mosi = mosi_q;
  assign done = done_q;
  assign rx_word = rx_q;

  function [3:0] bit_pos;
    input lsb;
    input [`LEN_W-1:0] n;
    input [`LEN_W-1:0] k;
    reg [`LEN_W-1:0] p;
    begin
      p = lsb ? k : (n - 5'h01 - k);
      bit_pos = p[3:0];
    end
  endfunction

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      hc_q <= {`HALF_W{1'b0}};
      half_q <= {`HALF_W{1'b0}};
      bitk_q <= {`LEN_W{1'b0}};
      nb_q <= {`LEN_W{1'b0}};
      cpha_q <= 1'b0;
      cpol_q <= 1'b0;
      lsb_q <= 1'b0;
      edge_odd_q <= 1'b0;
      tx_q <= {`DATA_W{1'b0}};
      rx_q <= {`DATA_W{1'b0}};
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        run_q <= 1'b0;
        sclk_q <= cpol_q;
      end else if (start) begin
        run_q <= 1'b1;
        hc_q <= {`HALF_W{1'b0}};
        half_q <= half_cyc;
        bitk_q <= {`LEN_W{1'b0}};
        nb_q <= nbits;
        cpha_q <= cpha;
        cpol_q <= cpol;
        lsb_q <= lsb_first;
        edge_odd_q <= 1'b0;
        tx_q <= tx_word;
        sclk_q <= cpol;
        if (!cpha) begin
          mosi_q <= tx_word[bit_pos(lsb_first, nbits, 5'h00)];
        end
      end else if (run_q) begin
        if (hc_q == half_q - 12'h001) begin
          hc_q <= {`HALF_W{1'b0}};
          sclk_q <= ~sclk_q;
          edge_odd_q <= ~edge_odd_q;
          if (edge_odd_q == cpha_q) begin
            rx_q[bit_pos(lsb_q, nb_q, bitk_q)] <= miso;
            bitk_q <= bitk_q + 5'h01;
            if (bitk_q == nb_q - 5'h01) begin
              done_q <= 1'b1;
              // Leading-edge sampling still owes the edge back to idle, so that run goes on for one half.
              run_q <= ~cpha_q;
            end
          end else if (bitk_q == nb_q) begin
            run_q <= 1'b0;
          end else begin
            mosi_q <= tx_q[bit_pos(lsb_q, nb_q, bitk_q)];
          end
        end else begin
          hc_q <= hc_q + 12'h001;
        end
      end
    end
  end

endmodule

// *** rtl/spi_master_sequencer_init.v ***
// Master-mode sequencer of the serial peripheral unit with enable and reset initialization.
`timescale 1ns/100ps
`include "spi_seq_defines.vh"

module spi_master_sequencer_init (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Control writes and configuration
  input wire ctrl_wr,
  input wire ctrl_enable_wdata,
  input wire ctrl_tx_irq_en_wdata,
  input wire master_bit,
  input wire select_mode_bit,
  input wire mode_fault_enable,
  input wire [`PTR_W-1:0] sequence_length_reg,
  input wire [7:0] bit_rate_reg,
  input wire [2:0] clock_delay_reg,
  input wire [2:0] negation_delay_reg,
  input wire [2:0] next_access_delay_reg,
  input wire [`SSL_N-1:0] select_polarity_reg,
  // Command registers
  input wire cmd_wr,
  input wire [`PTR_W-1:0] cmd_wr_index,
  input wire [`DATA_W-1:0] cmd_wr_data,
  // Status
  input wire overrun_clear,
  input wire mode_fault_clear,
  output wire unit_enable,
  output wire tx_irq_enable,
  output wire tx_empty_flag,
  output wire rx_full_flag,
  output wire overrun_flag,
  output wire mode_fault_flag,
  output wire tx_irq,
  output wire [`PTR_W-1:0] command_pointer,
  output wire [`PTR_W-1:0] error_command_pointer,
  // Data register
  input wire data_wr,
  input wire [`DATA_W-1:0] data_wdata,
  output wire rx_valid,
  input wire rx_ready,
  output wire [`DATA_W-1:0] rx_data,
  // Serial link
  output wire sclk_out,
  output wire sclk_oe,
  output wire mosi_out,
  output wire mosi_oe,
  input wire miso_in,
  output wire [`SSL_N-1:0] ssl_out,
  output wire [`SSL_N-1:0] ssl_oe,
  input wire ssl0_in
);

  localparam ST_IDLE = 3'h0;
  localparam ST_LEAD = 3'h1;
  localparam ST_XFER = 3'h2;
  localparam ST_NEG = 3'h3;
  localparam ST_NEXT = 3'h4;

  reg [1:0] rst_sync_q;
  wire rst_n;
  reg miso_s1_q;
  reg miso_s2_q;
  reg ssl0_s1_q;
  reg ssl0_s2_q;

  reg [`DATA_W-1:0] cmd_q [0:`NUM_CMD-1];
  reg unit_enable_q;
  reg tx_irq_en_q;
  reg tx_empty_q;
  reg overrun_q;
  reg mode_fault_q;
  reg [`PTR_W-1:0] ptr_q;
  reg [`PTR_W-1:0] err_ptr_q;
  reg [2:0] state_q;
  reg [`CNT_W-1:0] cnt_q;
  reg [`DATA_W-1:0] tx_buf_q;
  reg [`DATA_W-1:0] shift_q;
  reg shift_full_q;
  reg keep_q;
  reg ssl_act_q;
  reg [1:0] ssl_sel_q;
  reg [`SSL_N-1:0] ssl_out_q;
  reg drive_q;
  reg en_d;
  reg [`SSL_N-1:0] ssl_d;
  integer i;
  integer j;

  wire [`DATA_W-1:0] cur;
  wire [`HALF_W-1:0] half_cyc;
  wire [12:0] sck_cyc;
  wire multi_master;
  wire fault_det;
  wire disabling;
  wire enabling;
  wire running;
  wire eng_start;
  wire eng_done;
  wire [`DATA_W-1:0] eng_rx;
  wire rx_in_ready;

  // Converts a delay setting to clock cycles, in whole serial clock periods.
  function [`CNT_W-1:0] dly_cyc;
    input en;
    input [2:0] val;
    input [12:0] sck;
    reg [3:0] u;
    reg [16:0] p;
    begin
      u = en ? ({1'b0, val} + 4'h1) : 4'h1;
      p = u * sck;
      dly_cyc = p[`CNT_W-1:0];
    end
  endfunction

  function [`LEN_W-1:0] len_bits;
    input [3:0] code;
    begin
      len_bits = (code < `LEN_SHORT_CODE) ? `LEN_SHORT_BITS : ({1'b0, code} + 5'h01);
    end
  endfunction

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
      ssl0_s1_q <= 1'b1;
      ssl0_s2_q <= 1'b1;
    end else begin
      miso_s1_q <= miso_in;
      miso_s2_q <= miso_s1_q;
      ssl0_s1_q <= ssl0_in;
      ssl0_s2_q <= ssl0_s1_q;
    end
  end

  assign cur = cmd_q[ptr_q];
  assign half_cyc = ({4'h0, bit_rate_reg} + 12'h001) << cur[`CMD_DIV_HI:`CMD_DIV_LO];
  assign sck_cyc = {half_cyc, 1'b0};

  assign multi_master = master_bit & ~select_mode_bit & mode_fault_enable;
  assign fault_det = unit_enable_q & multi_master & (ssl0_s2_q == select_polarity_reg[0]);
  assign running = unit_enable_q & master_bit;

  always @* begin
    en_d = unit_enable_q;
    if (ctrl_wr) begin
      if (!ctrl_enable_wdata) begin
        en_d = 1'b0;
      end else if (!mode_fault_q) begin
        en_d = 1'b1;
      end
    end
    if (fault_det) begin
      en_d = 1'b0;
    end
  end
  assign disabling = unit_enable_q & ~en_d;
  assign enabling = ~unit_enable_q & en_d;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `NUM_CMD; i = i + 1) begin
        cmd_q[i] <= `CMD_RESET;
      end
      unit_enable_q <= 1'b0;
      tx_irq_en_q <= 1'b0;
      overrun_q <= 1'b0;
      mode_fault_q <= 1'b0;
      err_ptr_q <= `PTR_FIRST;
    end else begin
      if (cmd_wr) begin
        cmd_q[cmd_wr_index] <= cmd_wr_data;
      end
      unit_enable_q <= en_d;
      if (ctrl_wr) begin
        tx_irq_en_q <= ctrl_tx_irq_en_wdata;
      end
      if (overrun_clear) begin
        overrun_q <= 1'b0;
      end
      if (eng_done && !overrun_q && !rx_in_ready) begin
        overrun_q <= 1'b1;
      end
      if (mode_fault_clear) begin
        mode_fault_q <= 1'b0;
      end
      if (fault_det) begin
        mode_fault_q <= 1'b1;
      end
      if (fault_det || (eng_done && !overrun_q)) begin
        err_ptr_q <= ptr_q;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= {`CNT_W{1'b0}};
      tx_buf_q <= {`DATA_W{1'b0}};
      shift_q <= {`DATA_W{1'b0}};
      shift_full_q <= 1'b0;
      tx_empty_q <= 1'b1;
      keep_q <= 1'b0;
      ssl_act_q <= 1'b0;
      ssl_sel_q <= 2'h0;
      ptr_q <= `PTR_FIRST;
    end else if (disabling) begin
      state_q <= ST_IDLE;
      shift_full_q <= 1'b0;
      keep_q <= 1'b0;
      ssl_act_q <= 1'b0;
      tx_empty_q <= 1'b1;
    end else begin
      if (enabling) begin
        ptr_q <= `PTR_FIRST;
      end
      if (data_wr && tx_empty_q) begin
        tx_buf_q <= data_wdata;
        tx_empty_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (running && !tx_empty_q && !shift_full_q) begin
            shift_q <= tx_buf_q;
            shift_full_q <= 1'b1;
            tx_empty_q <= 1'b1;
            ssl_act_q <= 1'b1;
            ssl_sel_q <= cur[`CMD_SEL_HI:`CMD_SEL_LO];
            keep_q <= 1'b0;
            cnt_q <= dly_cyc(cur[`CMD_CKD_EN], clock_delay_reg, sck_cyc);
            state_q <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (eng_start) begin
            state_q <= ST_XFER;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        ST_XFER: begin
          if (eng_done) begin
            shift_full_q <= 1'b0;
            cnt_q <= dly_cyc(cur[`CMD_NEG_EN], negation_delay_reg, sck_cyc);
            state_q <= ST_NEG;
          end
        end
        ST_NEG: begin
          if (cnt_q <= 16'h0001) begin
            keep_q <= cur[`CMD_KEEP];
            if (!cur[`CMD_KEEP]) begin
              ssl_act_q <= 1'b0;
            end
            cnt_q <= dly_cyc(cur[`CMD_NXT_EN], next_access_delay_reg, sck_cyc) + `NXT_EXTRA;
            state_q <= ST_NEXT;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        ST_NEXT: begin
          if (cnt_q <= 16'h0001) begin
            if (ptr_q >= sequence_length_reg) begin
              ptr_q <= `PTR_FIRST;
            end else begin
              ptr_q <= ptr_q + 3'h1;
            end
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign eng_start = (state_q == ST_LEAD) && (cnt_q <= 16'h0001);

  spi_bit_engine u_engine (
    .clock(clock),
    .rst_n(rst_n),
    .abort(disabling),
    .start(eng_start),
    .tx_word(shift_q),
    .nbits(len_bits(cur[`CMD_LEN_HI:`CMD_LEN_LO])),
    .cpol(cur[`CMD_CPOL]),
    .cpha(cur[`CMD_CPHA]),
    .lsb_first(cur[`CMD_LSB_FIRST]),
    .half_cyc(half_cyc),
    .miso(miso_s2_q),
    .sclk(sclk_out),
    .mosi(mosi_out),
    .done(eng_done),
    .rx_word(eng_rx)
  );

  spi_two_entry_buffer u_rx_buf (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(eng_done & ~overrun_q),
    .in_ready(rx_in_ready),
    .in_data(eng_rx),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  always @* begin
    for (j = 0; j < `SSL_N; j = j + 1) begin
      ssl_d[j] = (ssl_act_q && (ssl_sel_q == j[1:0])) ? select_polarity_reg[j] : ~select_polarity_reg[j];
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ssl_out_q <= {`SSL_N{1'b1}};
      drive_q <= 1'b0;
    end else begin
      ssl_out_q <= ssl_d;
      drive_q <= en_d & master_bit;
    end
  end

  assign ssl_out = ssl_out_q;
  assign ssl_oe = {`SSL_N{drive_q}};
  assign sclk_oe = drive_q;
  assign mosi_oe = drive_q;

  assign command_pointer = ptr_q;
  assign error_command_pointer = err_ptr_q;
  assign unit_enable = unit_enable_q;
  assign tx_irq_enable = tx_irq_en_q;
  assign tx_empty_flag = tx_empty_q;
  assign rx_full_flag = ~rx_in_ready;
  assign overrun_flag = overrun_q;
  assign mode_fault_flag = mode_fault_q;
  assign tx_irq = tx_irq_en_q & tx_empty_q;

endmodule

// *** verification/spi_seq_checker.sv ***
// Port-level assertions for the master-mode sequencer.
`timescale 1ns/100ps
`include "spi_seq_defines.vh"
module spi_seq_checker (
  // Clock and reset
  input wire clock,
  input wire arst_n,
  // Inputs watched
  input wire ctrl_wr,
  input wire ctrl_enable_wdata,
  input wire master_bit,
  input wire select_mode_bit,
  input wire mode_fault_enable,
  input wire [`PTR_W-1:0] sequence_length_reg,
  input wire [`SSL_N-1:0] select_polarity_reg,
  input wire data_wr,
  // Outputs watched
  input wire unit_enable,
  input wire tx_irq_enable,
  input wire tx_empty_flag,
  input wire overrun_flag,
  input wire mode_fault_flag,
  input wire tx_irq,
  input wire [`PTR_W-1:0] command_pointer,
  input wire sclk_out,
  input wire sclk_oe,
  input wire mosi_oe,
  input wire [`SSL_N-1:0] ssl_out,
  input wire [`SSL_N-1:0] ssl_oe
);
  wire multi = master_bit && !select_mode_bit && mode_fault_enable;
  wire negated = (ssl_out == ~select_polarity_reg);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_irq_follows_flags: assert property (tx_irq == (tx_irq_enable && tx_empty_flag))
    else $error("transmit request does not follow enable and empty flag");
  a_disable_sets_empty: assert property ($fell(unit_enable) |-> ##[0:1] tx_empty_flag)
    else $error("transmit empty not set on disable");
  a_write_fills_buffer: assert property (data_wr && tx_empty_flag && !(ctrl_wr && !ctrl_enable_wdata)
    |=> !tx_empty_flag) else $error("accepted data write left buffer empty");
  a_fault_blocks_enable: assert property (mode_fault_flag && !unit_enable && ctrl_wr && ctrl_enable_wdata
    |=> !unit_enable) else $error("enable accepted during mode fault");
  a_enable_ptr_first: assert property ($rose(unit_enable) |-> command_pointer == 3'h0)
    else $error("pointer not at first command on enable");
  a_idle_ptr_kept: assert property (!unit_enable && !(ctrl_wr && ctrl_enable_wdata) |=> $stable(command_pointer))
    else $error("pointer changed while disabled");
  a_single_no_fault: assert property (!multi && !mode_fault_flag |=> !mode_fault_flag)
    else $error("mode fault raised outside multi-master mode");
  a_disabled_lines_idle: assert property (!unit_enable && $past(!unit_enable) |->
    !sclk_oe && !mosi_oe && !(|ssl_oe) && negated) else $error("outputs active while disabled");
  a_ptr_steps_wrap: assert property (unit_enable && $past(unit_enable) && command_pointer != $past(command_pointer)
    |-> command_pointer == (($past(command_pointer) >= sequence_length_reg) ? 3'h0 : $past(command_pointer) + 3'h1))
    else $error("pointer stepped wrongly");
  a_clock_needs_select: assert property ($rose(sclk_out) |-> !negated)
    else $error("serial clock moved with no select asserted");
  a_load_asserts_select: assert property ($rose(tx_empty_flag) && unit_enable |-> ##[0:2] !negated)
    else $error("select not asserted after shift load");
  c_overrun: cover property ($rose(overrun_flag));
  c_fault: cover property ($rose(mode_fault_flag));
  c_wrap: cover property (unit_enable && $past(command_pointer) == 3'h7 && command_pointer == 3'h0);
endmodule
bind spi_master_sequencer_init spi_seq_checker u_seq_checker (.clock(clock), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
  .ctrl_enable_wdata(ctrl_enable_wdata), .master_bit(master_bit), .select_mode_bit(select_mode_bit),
  .mode_fault_enable(mode_fault_enable), .sequence_length_reg(sequence_length_reg),
  .select_polarity_reg(select_polarity_reg), .data_wr(data_wr), .unit_enable(unit_enable),
  .tx_irq_enable(tx_irq_enable), .tx_empty_flag(tx_empty_flag), .overrun_flag(overrun_flag),
  .mode_fault_flag(mode_fault_flag), .tx_irq(tx_irq), .command_pointer(command_pointer), .sclk_out(sclk_out),
  .sclk_oe(sclk_oe), .mosi_oe(mosi_oe), .ssl_out(ssl_out), .ssl_oe(ssl_oe));

// *** verification/spi_slave_model.sv ***
// Behavioural slave that echoes the master's data line while any select line is active.
`timescale 1ns/100ps
module spi_slave_model (
  // Clock
  input wire clock,
  // Serial link
  input wire [3:0] slave_select,
  input wire [3:0] polarity,
  input wire mosi,
  output reg miso
);
  reg idle_q;
  wire selected = |(~(slave_select ^ polarity));
  initial idle_q = 1'b0;
  // A released line toggles every cycle so stale data is never mistaken for a reply.
  always @(posedge clock) idle_q <= ~idle_q;
  always @* begin
    miso = selected ? mosi : idle_q;
  end
endmodule

// *** verification/tb_spi_master_sequencer_init.sv ***
// Self-checking bench for the master-mode sequencer with a slave model.
`timescale 1ns/100ps
`include "spi_seq_defines.vh"
module tb_spi_master_sequencer_init;
  reg clock, arst_n, ctrl_wr, ctrl_enable_wdata, ctrl_tx_irq_en_wdata, master_bit, select_mode_bit;
  reg mode_fault_enable, cmd_wr, overrun_clear, mode_fault_clear, data_wr, rx_ready, ssl0_in, rx_rand;
  reg [2:0] sequence_length_reg, cmd_wr_index, clock_delay_reg, negation_delay_reg, next_access_delay_reg;
  reg [7:0] bit_rate_reg;
  reg [3:0] select_polarity_reg;
  reg [15:0] cmd_wr_data, data_wdata;
  wire unit_enable, tx_irq_enable, tx_empty_flag, rx_full_flag, overrun_flag, mode_fault_flag, tx_irq;
  wire rx_valid, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_in;
  wire [2:0] command_pointer, error_command_pointer;
  wire [15:0] rx_data;
  wire [3:0] ssl_out, ssl_oe;
  integer miscompares, cmp_count, rx_count, tx_count, i, n;
  reg [15:0] sent [0:15];
  spi_master_sequencer_init u_dut (.clock(clock), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
    .ctrl_enable_wdata(ctrl_enable_wdata), .ctrl_tx_irq_en_wdata(ctrl_tx_irq_en_wdata), .master_bit(master_bit),
    .select_mode_bit(select_mode_bit), .mode_fault_enable(mode_fault_enable),
    .sequence_length_reg(sequence_length_reg), .bit_rate_reg(bit_rate_reg), .clock_delay_reg(clock_delay_reg),
    .negation_delay_reg(negation_delay_reg), .next_access_delay_reg(next_access_delay_reg),
    .select_polarity_reg(select_polarity_reg), .cmd_wr(cmd_wr), .cmd_wr_index(cmd_wr_index),
    .cmd_wr_data(cmd_wr_data), .overrun_clear(overrun_clear), .mode_fault_clear(mode_fault_clear),
    .unit_enable(unit_enable), .tx_irq_enable(tx_irq_enable), .tx_empty_flag(tx_empty_flag),
    .rx_full_flag(rx_full_flag), .overrun_flag(overrun_flag), .mode_fault_flag(mode_fault_flag), .tx_irq(tx_irq),
    .command_pointer(command_pointer), .error_command_pointer(error_command_pointer), .data_wr(data_wr),
    .data_wdata(data_wdata), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in), .ssl_out(ssl_out),
    .ssl_oe(ssl_oe), .ssl0_in(ssl0_in));
  spi_slave_model u_slave (.clock(clock), .slave_select(ssl_out), .polarity(select_polarity_reg), .mosi(mosi_out),
    .miso(miso_in));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task check(input [8*16-1:0] what, input [15:0] exp, input [15:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tick(input integer k);
    repeat (k) @(negedge clock);
  endtask
  function [2:0] exp_ptr(input integer words, input [2:0] last);
    exp_ptr = words % (last + 1);
  endfunction
  function cond(input integer k);
    case (k)
      0: cond = tx_empty_flag === 1'b1;
      1: cond = overrun_flag === 1'b1;
      2: cond = command_pointer === n[2:0];
      default: cond = ssl_out !== ~select_polarity_reg;
    endcase
  endfunction
  task wait_for(input integer k);
    integer c;
    begin
      c = 0;
      while (!cond(k) && c < 4000) begin
        tick(1);
        c = c + 1;
      end
      if (c == 4000) begin
        miscompares = miscompares + 1;
        $display("BAD wait %0d expected 1 seen 0", k);
        print_verdict;
      end
    end
  endtask
  task ctrl(input en, input ie);
    begin
      {ctrl_wr, ctrl_enable_wdata, ctrl_tx_irq_en_wdata} = {1'b1, en, ie};
      tick(1);
      ctrl_wr = 1'b0;
      tick(1);
    end
  endtask
  task send(input [15:0] w);
    begin
      wait_for(0);
      sent[tx_count % 16] = w;
      tx_count = tx_count + 1;
      {data_wr, data_wdata} = {1'b1, w};
      tick(1);
      data_wr = 1'b0;
    end
  endtask
  task stream(input [2:0] len);
    begin
      ctrl(0, 0);
      sequence_length_reg = len;
      ctrl(1, 0);
      check("ptr_on_enable", 0, command_pointer);
      {rx_count, tx_count} = 0;
      rx_rand = 1'b1;
      for (i = 0; i < len + 2; i = i + 1)
        send($urandom);
      wait_for(0);
      n = exp_ptr(len + 2, len);
      wait_for(2);
      tick(40);
      check("rx_count", len + 2, rx_count);
      check("pointer", n, command_pointer);
      $display("stream test with last command %0d done", len);
    end
  endtask
  always @(posedge clock) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check("rx_data", sent[rx_count % 16], rx_data);
      rx_count = rx_count + 1;
    end
  end
  always @(negedge clock) if (rx_rand) rx_ready <= $urandom % 2;
  initial begin
    {miscompares, cmp_count, rx_count, rx_rand, arst_n, ctrl_wr, ctrl_enable_wdata, ctrl_tx_irq_en_wdata} = 0;
    {select_mode_bit, mode_fault_enable, cmd_wr, overrun_clear, mode_fault_clear, data_wr, rx_ready, tx_count} = 0;
    {master_bit, ssl0_in, sequence_length_reg, cmd_wr_index, select_polarity_reg} = 12'hC00;
    {bit_rate_reg, cmd_wr_data, data_wdata} = {8'h02, 32'h0};
    n = $urandom(26498);
    {clock_delay_reg, negation_delay_reg, next_access_delay_reg} = 9'($urandom);
    tick(4);
    arst_n = 1'b1;
    tick(3);
    check("tx_empty", 1, tx_empty_flag);
    check("flags", 0, {unit_enable, rx_full_flag, overrun_flag, mode_fault_flag, tx_irq_enable});
    check("pointers", 0, {command_pointer, error_command_pointer});
    check("select", 16'h000F, ssl_out);
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1) begin
      {cmd_wr, cmd_wr_index, cmd_wr_data} = {1'b1, i[2:0], (16'($urandom) & 16'hF0B7) | 16'h0F00};
      tick(1);
    end
    cmd_wr = 1'b0;
    stream(3'h7);
    stream(3'($urandom % 7 + 1));
    rx_rand = 1'b0;
    tick(1);
    {rx_ready, rx_count, tx_count} = 0;
    for (i = 0; i < 3; i = i + 1)
      send($urandom);
    wait_for(1);
    check("rx_full", 1, rx_full_flag);
    ctrl(0, 1);
    check("tx_irq", 1, tx_irq);
    check("kept_flags", 3, {rx_full_flag, overrun_flag});
    ctrl(0, 0);
    check("tx_irq_off", 0, tx_irq);
    rx_ready = 1'b1;
    tick(4);
    check("drained", 2, rx_count);
    check("overrun_kept", 1, overrun_flag);
    overrun_clear = 1'b1;
    tick(1);
    overrun_clear = 1'b0;
    tick(1);
    check("overrun_clear", 0, overrun_flag);
    $display("overrun test done");
    ctrl(1, 0);
    send(16'h5A5A);
    wait_for(3);
    tick(12);
    n = rx_count;
    ctrl(0, 0);
    tick(1);
    check("abort_select", 16'h000F, ssl_out);
    check("abort_oe", 0, {sclk_oe, mosi_oe, ssl_oe});
    check("abort_empty", 1, tx_empty_flag);
    tick(300);
    check("abort_no_word", n, rx_count);
    $display("abort test done");
    mode_fault_enable = 1'b1;
    ctrl(1, 0);
    ssl0_in = 1'b0;
    tick(6);
    check("fault", 1, mode_fault_flag);
    check("fault_off", 0, unit_enable);
    ctrl(1, 0);
    check("fault_block", 0, unit_enable);
    ssl0_in = 1'b1;
    tick(4);
    mode_fault_clear = 1'b1;
    tick(1);
    {mode_fault_clear, mode_fault_enable} = 2'b00;
    tick(2);
    ctrl(1, 0);
    check("enable_again", 1, unit_enable);
    ssl0_in = 1'b0;
    tick(6);
    check("single_no_fault", 1, {mode_fault_flag, unit_enable});
    ssl0_in = 1'b1;
    $display("mode fault test done");
    print_verdict;
  end
endmodule
